// *** core/tcu_pkg.sv ***
//------------------------------------------------------------------------------
// What this block does
// - count source: stop, cpu/12, cpu/24, prescaled osc
// - prescale field divides osc by 128 down to 1
// - reload enable copies channel 0 on overflow
// - output method: direct, or software-chosen level
// - edge select 0: channel 0 flags on leaving equal
// - edge select 1: channel 0 flags on becoming equal
// - channel 0 pin capture edge follows edge select
// - channel 3 mode: off, pin, compare, software capture
// - channel 2 mode: off, pin, compare, software capture
// - channel 1 mode: off, pin, compare, software capture
// - channel 0 mode: off, pin, compare, software capture
// - counter readable, writable by byte, resets zero
// - four 16-bit channel values, writable, reset zero
// - overflow flag set on wrap, software accessible
// - compare match sets channel flag, software accessible
// - direct output high when counter reaches channel value
// - software writes only clear flags, never set
//------------------------------------------------------------------------------

package tcu_pkg;

    //--------------------------------------------------------------------------
    // register indices, byte address is four times the index
    //--------------------------------------------------------------------------
    localparam logic [7:0] IDX_FLAGS = 8'hC0;      // timer_request_flags
    localparam logic [7:0] IDX_MODE = 8'hC1;       // channel_mode_select
    localparam logic [7:0] IDX_CH1_LO = 8'hC2;     // channel1_value_low
    localparam logic [7:0] IDX_CH1_HI = 8'hC3;     // channel1_value_high
    localparam logic [7:0] IDX_CH2_LO = 8'hC4;     // channel2_value_low
    localparam logic [7:0] IDX_CH2_HI = 8'hC5;     // channel2_value_high
    localparam logic [7:0] IDX_CH3_LO = 8'hC6;     // channel3_value_low
    localparam logic [7:0] IDX_CH3_HI = 8'hC7;     // channel3_value_high
    localparam logic [7:0] IDX_CTRL = 8'hC8;       // timer_control
    localparam logic [7:0] IDX_RATE = 8'hC9;       // prescale_control
    localparam logic [7:0] IDX_CH0_LO = 8'hCA;     // channel0_value_low
    localparam logic [7:0] IDX_CH0_HI = 8'hCB;     // channel0_value_high
    localparam logic [7:0] IDX_CNT_LO = 8'hCC;     // counter_low
    localparam logic [7:0] IDX_CNT_HI = 8'hCD;     // counter_high
    localparam logic [7:0] IDX_NEXT_LEVEL = 8'hCE; // indirect output levels

    //--------------------------------------------------------------------------
    // field positions and masks
    //--------------------------------------------------------------------------
    localparam int unsigned BIT_EDGE_SEL = 6;      // match_edge_select
    localparam int unsigned BIT_RELOAD = 4;        // reload_enable
    localparam int unsigned BIT_METHOD = 2;        // output_method
    localparam int unsigned BIT_OVF_FLAG = 6;      // overflow_flag
    localparam int unsigned BIT_MATCH_LSB = 2;     // match_flag0 position
    localparam logic [7:0] CTRL_MASK = 8'h57;      // writable control bits
    localparam logic [7:0] RATE_MASK = 8'h07;      // writable prescale bits
    localparam logic [7:0] LEVEL_MASK = 8'h0F;     // writable level bits
    localparam logic [7:0] RESET_BYTE = 8'h00;     // every register resets here

    //--------------------------------------------------------------------------
    // counter constants
    //--------------------------------------------------------------------------
    localparam logic [15:0] CNT_MAX = 16'hFFFF;    // wrap point
    localparam logic [15:0] CNT_ZERO = 16'h0000;   // value after plain wrap
    localparam logic [7:0] DIV_CPU12 = 8'h0C;      // cpu clock / 12
    localparam logic [7:0] DIV_CPU24 = 8'h18;      // cpu clock / 24
    localparam logic [7:0] DIV_OSC_MAX = 8'h80;    // osc / 128 at rate 000
    localparam int unsigned PADDR_W = 12;          // apb address width

    //--------------------------------------------------------------------------
    // enumerations
    //--------------------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_STOP = 2'h0,
        SRC_CPU12 = 2'h1,
        SRC_CPU24 = 2'h2,
        SRC_OSC = 2'h3
    } tcu_source_t;

    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_CAP_PIN = 2'h1,
        MODE_CMP = 2'h2,
        MODE_CAP_SW = 2'h3
    } tcu_mode_t;

endpackage

// *** core/tcu_tick_gen.sv ***
`timescale 1ns/1ns
`default_nettype none

//------------------------------------------------------------------------------
// count enable generator
//------------------------------------------------------------------------------
module tcu_tick_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] count_source,
    input wire logic [2:0] oscillator_prescale,
    output logic tick
);

    logic [7:0] div_reg;   // cycles since last tick
    logic [7:0] period;    // cycles between ticks

    // period picked from source and rate
    always_comb begin
        case (tcu_pkg::tcu_source_t'(count_source))
            tcu_pkg::SRC_CPU12: period = tcu_pkg::DIV_CPU12;
            tcu_pkg::SRC_CPU24: period = tcu_pkg::DIV_CPU24;
            // oscillator taken as pclk, rate 000 divides by 128
            tcu_pkg::SRC_OSC: period = tcu_pkg::DIV_OSC_MAX >> oscillator_prescale;
            default: period = tcu_pkg::DIV_OSC_MAX;
        endcase
    end

    // divider; >= guards a period shortened mid-count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 8'h00;
            tick <= 1'b0;
        end else if (count_source == tcu_pkg::SRC_STOP) begin
            // stopped: no ticks, divider parked
            div_reg <= 8'h00;
            tick <= 1'b0;
        end else if (div_reg + 8'h01 >= period) begin
            div_reg <= 8'h00;
            tick <= 1'b1;
        end else begin
            div_reg <= div_reg + 8'h01;
            tick <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// *** core/tcu_timer.sv ***
`timescale 1ns/1ns
`default_nettype none

//------------------------------------------------------------------------------
// timer with four compare / capture channels, apb slave
//------------------------------------------------------------------------------
module tcu_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tcu_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] capture_pin,
    output logic [3:0] compare_pin
);

    //--------------------------------------------------------------------------
    // helper functions
    //--------------------------------------------------------------------------

    // low byte index of a channel
    function automatic logic [7:0] lo_index(input int unsigned ch);
        case (ch)
            0: lo_index = tcu_pkg::IDX_CH0_LO;
            1: lo_index = tcu_pkg::IDX_CH1_LO;
            2: lo_index = tcu_pkg::IDX_CH2_LO;
            default: lo_index = tcu_pkg::IDX_CH3_LO;
        endcase
    endfunction

    // high byte index of a channel
    function automatic logic [7:0] hi_index(input int unsigned ch);
        case (ch)
            0: hi_index = tcu_pkg::IDX_CH0_HI;
            1: hi_index = tcu_pkg::IDX_CH1_HI;
            2: hi_index = tcu_pkg::IDX_CH2_HI;
            default: hi_index = tcu_pkg::IDX_CH3_HI;
        endcase
    endfunction

    // any index the block answers
    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx >= tcu_pkg::IDX_FLAGS) && (idx <= tcu_pkg::IDX_NEXT_LEVEL);
    endfunction

    //--------------------------------------------------------------------------
    // state
    //--------------------------------------------------------------------------
    logic [7:0] ctrl_reg;          // timer_control
    logic [7:0] rate_reg;          // prescale_control
    logic [7:0] mode_reg;          // channel_mode_select
    logic [7:0] level_reg;         // indirect next output levels
    logic [15:0] cnt_reg;          // counter
    logic [15:0] val_reg [4];      // channel values
    logic ovf_flag_reg;            // overflow_flag
    logic [3:0] match_flag_reg;    // match_flag3..0
    logic [3:0] eq_last_reg;       // equality seen last cycle
    logic [3:0] pin_meta_reg;      // synchroniser first stage
    logic [3:0] pin_sync_reg;      // synchroniser second stage
    logic [3:0] pin_last_reg;      // previous synced level
    logic [3:0] cmp_out_reg;       // compare pin drivers
    logic [31:0] prdata_reg;       // read data
    logic pready_reg;              // access phase answer
    logic pslverr_reg;             // unmapped address

    //--------------------------------------------------------------------------
    // bus decode
    //--------------------------------------------------------------------------
    logic [7:0] idx;           // word index
    logic addr_ok;             // aligned and in range
    logic setup;               // setup cycle
    logic wr;                  // write commits this edge
    logic tick;                // counter advance
    logic edge_sel;            // match_edge_select
    logic reload_en;           // reload_enable
    logic method;              // output_method
    logic [1:0] count_source;  // count_source
    logic cnt_write;           // software touches counter
    logic ovf;                 // wrap event
    logic [3:0] eq;            // counter equals channel
    logic [3:0] in_cmp;        // channel in compare mode
    logic [3:0] match_set;     // flag set events
    logic [3:0] cap_pin;       // pin capture events
    logic [3:0] rise;          // synced rising edges
    logic [3:0] fall;          // synced falling edges

    assign idx = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[tcu_pkg::PADDR_W-1:10] == '0) && is_mapped(idx);
    assign setup = psel && !penable;
    // writes land only on the edge that sees pready
    assign wr = psel && penable && pwrite && pready_reg && addr_ok;

    assign edge_sel = ctrl_reg[tcu_pkg::BIT_EDGE_SEL];
    assign reload_en = ctrl_reg[tcu_pkg::BIT_RELOAD];
    assign method = ctrl_reg[tcu_pkg::BIT_METHOD];
    assign count_source = ctrl_reg[1:0];

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign compare_pin = cmp_out_reg;

    //--------------------------------------------------------------------------
    // count enable
    //--------------------------------------------------------------------------
    tcu_tick_gen u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .count_source(count_source),
        .oscillator_prescale(rate_reg[2:0]),
        .tick(tick)
    );

    //--------------------------------------------------------------------------
    // apb answer
    //--------------------------------------------------------------------------

    // answer prepared in setup, so the access phase lasts one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup && !addr_ok;
        end
    end

    // read mux, sampled in setup; reserved bits read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup && !pwrite && addr_ok) begin
            case (idx)
                tcu_pkg::IDX_FLAGS: prdata_reg <= {24'h00_0000, 1'b0, ovf_flag_reg, match_flag_reg, 2'b00};
                tcu_pkg::IDX_MODE: prdata_reg <= {24'h00_0000, mode_reg};
                tcu_pkg::IDX_CTRL: prdata_reg <= {24'h00_0000, ctrl_reg};
                tcu_pkg::IDX_RATE: prdata_reg <= {24'h00_0000, rate_reg};
                tcu_pkg::IDX_CH0_LO: prdata_reg <= {24'h00_0000, val_reg[0][7:0]};
                tcu_pkg::IDX_CH0_HI: prdata_reg <= {24'h00_0000, val_reg[0][15:8]};
                tcu_pkg::IDX_CH1_LO: prdata_reg <= {24'h00_0000, val_reg[1][7:0]};
                tcu_pkg::IDX_CH1_HI: prdata_reg <= {24'h00_0000, val_reg[1][15:8]};
                tcu_pkg::IDX_CH2_LO: prdata_reg <= {24'h00_0000, val_reg[2][7:0]};
                tcu_pkg::IDX_CH2_HI: prdata_reg <= {24'h00_0000, val_reg[2][15:8]};
                tcu_pkg::IDX_CH3_LO: prdata_reg <= {24'h00_0000, val_reg[3][7:0]};
                tcu_pkg::IDX_CH3_HI: prdata_reg <= {24'h00_0000, val_reg[3][15:8]};
                tcu_pkg::IDX_CNT_LO: prdata_reg <= {24'h00_0000, cnt_reg[7:0]};
                tcu_pkg::IDX_CNT_HI: prdata_reg <= {24'h00_0000, cnt_reg[15:8]};
                tcu_pkg::IDX_NEXT_LEVEL: prdata_reg <= {24'h00_0000, level_reg};
                default: prdata_reg <= 32'h0000_0000;
            endcase
        end else begin
            prdata_reg <= 32'h0000_0000;
        end
    end

    //--------------------------------------------------------------------------
    // configuration registers
    //--------------------------------------------------------------------------

    // control, prescale, mode and level bytes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= tcu_pkg::RESET_BYTE;
            rate_reg <= tcu_pkg::RESET_BYTE;
            mode_reg <= tcu_pkg::RESET_BYTE;
            level_reg <= tcu_pkg::RESET_BYTE;
        end else if (wr) begin
            case (idx)
                tcu_pkg::IDX_CTRL: ctrl_reg <= pwdata[7:0] & tcu_pkg::CTRL_MASK;
                tcu_pkg::IDX_RATE: rate_reg <= pwdata[7:0] & tcu_pkg::RATE_MASK;
                tcu_pkg::IDX_MODE: mode_reg <= pwdata[7:0];
                tcu_pkg::IDX_NEXT_LEVEL: level_reg <= pwdata[7:0] & tcu_pkg::LEVEL_MASK;
                default: ;
            endcase
        end
    end

    //--------------------------------------------------------------------------
    // counter
    //--------------------------------------------------------------------------
    assign cnt_write = wr && ((idx == tcu_pkg::IDX_CNT_LO) || (idx == tcu_pkg::IDX_CNT_HI));
    // a software write in the same cycle beats the count, so no wrap then
    assign ovf = tick && !cnt_write && (cnt_reg == tcu_pkg::CNT_MAX);

    // count up, wrap or reload, byte writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= tcu_pkg::CNT_ZERO;
        end else if (cnt_write) begin
            if (idx == tcu_pkg::IDX_CNT_LO) begin
                cnt_reg[7:0] <= pwdata[7:0];
            end else begin
                cnt_reg[15:8] <= pwdata[7:0];
            end
        end else if (ovf) begin
            // reload makes the counter run from channel 0 up to the top
            cnt_reg <= reload_en ? val_reg[0] : tcu_pkg::CNT_ZERO;
        end else if (tick) begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end

    //--------------------------------------------------------------------------
    // compare detection
    //--------------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            eq[i] = (cnt_reg == val_reg[i]);
            in_cmp[i] = (mode_reg[2*i +: 2] == tcu_pkg::MODE_CMP);
            match_set[i] = in_cmp[i] && eq[i] && !eq_last_reg[i];
        end
        // channel 0 may flag on leaving equality instead
        if (!edge_sel) begin
            match_set[0] = in_cmp[0] && !eq[0] && eq_last_reg[0];
        end else begin
            match_set[0] = in_cmp[0] && eq[0] && !eq_last_reg[0];
        end
    end

    // equality history, always tracked so enabling compare is quiet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eq_last_reg <= 4'h0;
        end else begin
            eq_last_reg <= eq;
        end
    end

    //--------------------------------------------------------------------------
    // request flags
    //--------------------------------------------------------------------------

    // hardware set wins over a clearing write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_flag_reg <= 1'b0;
            match_flag_reg <= 4'h0;
        end else begin
            if (ovf) begin
                ovf_flag_reg <= 1'b1;
            end else if (wr && idx == tcu_pkg::IDX_FLAGS && !pwdata[tcu_pkg::BIT_OVF_FLAG]) begin
                ovf_flag_reg <= 1'b0;
            end
            for (int i = 0; i < 4; i++) begin
                if (match_set[i]) begin
                    match_flag_reg[i] <= 1'b1;
                end else if (wr && idx == tcu_pkg::IDX_FLAGS && !pwdata[tcu_pkg::BIT_MATCH_LSB + i]) begin
                    match_flag_reg[i] <= 1'b0;
                end
            end
        end
    end

    //--------------------------------------------------------------------------
    // capture pins
    //--------------------------------------------------------------------------

    // two-stage synchroniser plus edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
            pin_last_reg <= 4'h0;
        end else begin
            pin_meta_reg <= capture_pin;
            pin_sync_reg <= pin_meta_reg;
            pin_last_reg <= pin_sync_reg;
        end
    end

    assign rise = pin_sync_reg & ~pin_last_reg;
    assign fall = ~pin_sync_reg & pin_last_reg;

    // one pulse per synced edge, hence one capture per edge
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cap_pin[i] = (mode_reg[2*i +: 2] == tcu_pkg::MODE_CAP_PIN) && rise[i];
        end
        cap_pin[0] = (mode_reg[1:0] == tcu_pkg::MODE_CAP_PIN) && (edge_sel ? rise[0] : fall[0]);
    end

    //--------------------------------------------------------------------------
    // channel values
    //--------------------------------------------------------------------------

    // pin capture wins over a byte write landing the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                val_reg[i] <= {tcu_pkg::RESET_BYTE, tcu_pkg::RESET_BYTE};
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (cap_pin[i]) begin
                    val_reg[i] <= cnt_reg;
                end else if (wr && idx == lo_index(i)) begin
                    if (mode_reg[2*i +: 2] == tcu_pkg::MODE_CAP_SW) begin
                        // software capture: written data is dropped
                        val_reg[i] <= cnt_reg;
                    end else begin
                        val_reg[i][7:0] <= pwdata[7:0];
                    end
                end else if (wr && idx == hi_index(i)) begin
                    val_reg[i][15:8] <= pwdata[7:0];
                end
            end
        end
    end

    //--------------------------------------------------------------------------
    // compare outputs
    //--------------------------------------------------------------------------

    // pins lag the counter by one clock, since they come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_out_reg <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (!in_cmp[i]) begin
                    // channel not comparing: pin parked low
                    cmp_out_reg[i] <= 1'b0;
                end else if (!method) begin
                    cmp_out_reg[i] <= (cnt_reg >= val_reg[i]);
                end else if (eq[i] && !eq_last_reg[i]) begin
                    // indirect: level chosen ahead by software, overflow leaves it
                    cmp_out_reg[i] <= level_reg[i];
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** tb/tcu_props.sv ***
`timescale 1ns/1ns
`default_nettype none
// apb answer shape and register read-back, seen from the timer's ports only
module tcu_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tcu_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] compare_pin
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic [7:0] idx = paddr[9:2]; // word index of the access
    wire logic rd_done = pready && !pwrite; // read data valid now
    ready_after_setup_a: assert property (psel && !penable |=> pready && penable)
        else $error("pready missing after setup");
    ready_pulse_a: assert property (pready |-> $past(psel) && !$past(penable) ##1 !pready)
        else $error("pready not a single pulse");
    idle_data_zero_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("answer outside access");
    misaligned_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access accepted");
    error_data_zero_a: assert property (rd_done && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    flag_spare_a: assert property (rd_done && idx == tcu_pkg::IDX_FLAGS |-> (prdata & 32'hFFFFFF83) == 32'h0)
        else $error("spare flag bits set");
    ctrl_spare_a: assert property (rd_done && idx == tcu_pkg::IDX_CTRL |-> (prdata & 32'hFFFFFFA8) == 32'h0)
        else $error("spare control bits set");
    rate_spare_a: assert property (rd_done && idx == tcu_pkg::IDX_RATE |-> prdata[7:3] == 5'h0)
        else $error("spare prescale bits set");
    cover property (rd_done && idx == tcu_pkg::IDX_FLAGS && prdata[6]);
    cover property (compare_pin == 4'hF);
    cover property (pready && pslverr);
endmodule
bind tcu_timer tcu_props i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .compare_pin);
`default_nettype wire

// *** tb/tcu_pin_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// board side of the capture inputs, launched just after a rising edge
module tcu_pin_model (
    input wire logic pclk,
    input wire logic [3:0] pin_level,
    output logic [3:0] capture_pin
);
    initial capture_pin = 4'h0; // quiet pins before the first edge
    always @(posedge pclk) capture_pin <= pin_level; // same pclk edge the timer samples on, so its synchroniser takes it one edge later
endmodule
`default_nettype wire

// *** tb/test_timer_compare_capture_unit.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_timer_compare_capture_unit;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pin_level, capture_pin, compare_pin;
    logic [8:0] got; // error flag and byte of the last transfer
    logic [7:0] lo_idx [4] = '{8'hCA, 8'hC2, 8'hC4, 8'hC6}; // channel low bytes, high is one above
    int num_errors = 0;
    int checked = 0;
    tcu_timer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .capture_pin, .compare_pin);
    tcu_pin_model i_pins (.pclk, .pin_level, .capture_pin);
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer; request held until pready is sampled, then a quiet edge
    task automatic w(input logic [7:0] idx, input logic [7:0] d, input logic wr = 1'b1, input logic [1:0] off = 2'h0);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, off};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        got = {pslverr, prdata[7:0]};
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic r(input string what, input logic [7:0] idx, input logic [7:0] exp);
        w(idx, 8'h00, 1'b0);
        check(what, exp, got[7:0]);
    endtask
    task automatic t_regs();
        for (int i = 'hC0; i <= 'hCE; i++) r("reset value", i[7:0], 8'h00);
        w(8'hD0, 8'h00, 1'b0);
        check("unmapped error", 8'h01, {7'h0, got[8]});
        w(tcu_pkg::IDX_CTRL, 8'hFF, 1'b1, 2'h1);
        r("misaligned ignored", tcu_pkg::IDX_CTRL, 8'h00);
        w(tcu_pkg::IDX_CTRL, 8'hFF);
        r("control", tcu_pkg::IDX_CTRL, 8'h57);
        w(tcu_pkg::IDX_CTRL, 8'h00);
        w(tcu_pkg::IDX_FLAGS, 8'hFF);
        r("flags", tcu_pkg::IDX_FLAGS, 8'h00);
    endtask
    // run 16 ticks' worth of cycles; window allows for start and stop latency
    task automatic t_rate(input logic [1:0] src, input logic [2:0] rate, input int div);
        w(tcu_pkg::IDX_CNT_LO, 8'h00);
        w(tcu_pkg::IDX_RATE, {5'h0, rate});
        w(tcu_pkg::IDX_CTRL, {6'h0, src});
        repeat (16 * div) @(posedge pclk);
        w(tcu_pkg::IDX_CTRL, 8'h00);
        w(tcu_pkg::IDX_CNT_LO, 8'h00, 1'b0);
        check("ticks", 8'h01, {7'h0, got[7:0] >= 8'h0F && got[7:0] <= 8'h13});
    endtask
    task automatic t_overflow();
        w(tcu_pkg::IDX_CH0_LO, 8'h34);
        w(tcu_pkg::IDX_CH0_HI, 8'h12);
        w(tcu_pkg::IDX_CNT_HI, 8'hFF);
        w(tcu_pkg::IDX_CNT_LO, 8'hFE);
        w(tcu_pkg::IDX_RATE, 8'h07);
        w(tcu_pkg::IDX_CTRL, 8'h13);
        w(tcu_pkg::IDX_CTRL, 8'h00);
        r("overflow flag", tcu_pkg::IDX_FLAGS, 8'h40);
        r("reloaded counter", tcu_pkg::IDX_CNT_HI, 8'h12);
        w(tcu_pkg::IDX_FLAGS, 8'h00);
        r("flag cleared", tcu_pkg::IDX_FLAGS, 8'h00);
    endtask
    task automatic t_compare();
        w(tcu_pkg::IDX_MODE, 8'hAA);
        w(tcu_pkg::IDX_CTRL, 8'h40);
        for (int i = 0; i < 4; i++) begin
            w(lo_idx[i], 8'h10);
            w(lo_idx[i] + 8'h01, 8'h00);
        end
        w(tcu_pkg::IDX_CNT_HI, 8'h00);
        w(tcu_pkg::IDX_CNT_LO, 8'h0F);
        @(posedge pclk);
        check("pins below", 8'h00, {4'h0, compare_pin});
        w(tcu_pkg::IDX_CNT_LO, 8'h10);
        @(posedge pclk);
        check("pins at value", 8'h0F, {4'h0, compare_pin});
        r("match flags", tcu_pkg::IDX_FLAGS, 8'h3C);
        w(tcu_pkg::IDX_FLAGS, 8'h00);
        w(tcu_pkg::IDX_CTRL, 8'h00);
        w(tcu_pkg::IDX_CNT_LO, 8'h11);
        r("leaving equal", tcu_pkg::IDX_FLAGS, 8'h04);
        w(tcu_pkg::IDX_CTRL, 8'h04);
        w(tcu_pkg::IDX_NEXT_LEVEL, 8'h05);
        w(tcu_pkg::IDX_CNT_LO, 8'h10);
        @(posedge pclk);
        check("indirect pins", 8'h05, {4'h0, compare_pin});
    endtask
    task automatic t_capture();
        w(tcu_pkg::IDX_MODE, 8'hFF);
        w(tcu_pkg::IDX_CNT_LO, 8'h45);
        for (int i = 0; i < 4; i++) begin
            w(lo_idx[i], 8'hAA);
            r("software capture", lo_idx[i], 8'h45);
        end
        w(tcu_pkg::IDX_MODE, 8'h55);
        w(tcu_pkg::IDX_CNT_LO, 8'h77);
        pin_level <= 4'hF;
        repeat (6) @(posedge pclk);
        w(tcu_pkg::IDX_CNT_LO, 8'h88);
        pin_level <= 4'h0;
        repeat (6) @(posedge pclk);
        for (int i = 0; i < 4; i++) r("pin capture", lo_idx[i], (i == 0) ? 8'h88 : 8'h77);
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pin_level} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        for (int k = 0; k < 8; k++) t_rate(2'h3, k[2:0], 128 >> k);
        t_rate(2'h1, 3'h0, 12);
        t_rate(2'h2, 3'h0, 24);
        t_overflow();
        t_compare();
        t_capture();
        summarize();
    end
    // hang guard, well beyond the roughly five thousand cycles of the run
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        summarize();
    end
endmodule
`default_nettype wire
